// [rtl/rsc_map.vh]
// constants for the reference select control register
`ifndef RSC_MAP_VH
`define RSC_MAP_VH
`define RSC_ADDR_W          8
`define RSC_DATA_W          8
`define RSC_REG_ADDR        8'hd1
`define RSC_RESET_VAL       8'h00
`define RSC_WRITE_MASK      8'h1f
`define RSC_BIT_CONV0_SEL   4
`define RSC_BIT_CONV1_SEL   3
`define RSC_BIT_TEMP_EN     2
`define RSC_BIT_BIAS_EN     1
`define RSC_BIT_BUF_EN      0
`define RSC_FIELD_W         5
`define RSC_FIELD_RESET     5'h00
`endif

// [rtl/rsc_field_reg.v]
// storage flops for the defined bits of the control register
`timescale 1ns/1ps
`default_nettype none
`include "rsc_map.vh"

module rsc_field_reg (
  // clock and reset
  input  wire                    clk_in,
  input  wire                    rst_b_in,
  // write port
  input  wire                    wr_en_in,
  input  wire [`RSC_FIELD_W-1:0] wr_data_in,
  // stored value
  output reg  [`RSC_FIELD_W-1:0] field_out
);

  // ----------------------------------------
  // storage
  // ----------------------------------------
  always @(posedge clk_in) begin
    if (!rst_b_in) begin
      field_out <= `RSC_FIELD_RESET;
    end else if (wr_en_in) begin
      field_out <= wr_data_in;
    end
  end

endmodule // rsc_field_reg
`default_nettype wire

// [rtl/rsc_ref_ctrl.v]
// reference select control register on the special-function bus
`timescale 1ns/1ps
`default_nettype none
`include "rsc_map.vh"

// Overview of operation
// - bit four selects first converter reference: pin when clear, first DAC when set.
// - bit three selects second converter reference: pin when clear, supply when set.
// - bit two turns the temperature sensor on; clear leaves it high impedance.
// - bit zero enables the reference buffer; clear makes its output high impedance.
module rsc_ref_ctrl (
  // clock and reset
  input  wire                  clk_in,
  input  wire                  rst_b_in,
  // special-function bus
  input  wire [`RSC_ADDR_W-1:0] sfr_addr_in,
  input  wire                  sfr_wr_in,
  input  wire                  sfr_rd_in,
  input  wire [`RSC_DATA_W-1:0] sfr_wdata_in,
  output reg  [`RSC_DATA_W-1:0] sfr_rdata_out,
  output reg                   sfr_hit_out,
  // analog controls
  output reg                   conv0_ref_select_out,
  output reg                   conv1_ref_select_out,
  output reg                   temp_sensor_enable_out,
  output reg                   bias_generator_enable_out,
  output reg                   ref_buffer_enable_out
);

  // ----------------------------------------
  // helper functions
  // ----------------------------------------
  // address compare shared by the read and write paths
  function addr_hit;
    input [`RSC_ADDR_W-1:0] a;
    begin
      addr_hit = (a == `RSC_REG_ADDR);
    end
  endfunction

  // keep only the defined low bits of a bus byte
  function [`RSC_FIELD_W-1:0] defined_bits;
    input [`RSC_DATA_W-1:0] d;
    begin
      defined_bits = d[`RSC_FIELD_W-1:0];
    end
  endfunction

  // widen the stored bits to a bus byte, unused bits as zero
  function [`RSC_DATA_W-1:0] read_word;
    input [`RSC_FIELD_W-1:0] f;
    begin
      read_word = {{(`RSC_DATA_W-`RSC_FIELD_W){1'h0}}, f};
    end
  endfunction

  // pick one defined bit of the stored field
  function field_bit;
    input [`RSC_FIELD_W-1:0] f;
    input integer            pos;
    begin
      field_bit = f[pos];
    end
  endfunction

  // reset value of one bit, taken from the register's reset byte
  function reset_bit;
    input integer pos;
    reg [`RSC_DATA_W-1:0] rv;
    begin
      rv        = `RSC_RESET_VAL;
      reset_bit = rv[pos];
    end
  endfunction

  // ----------------------------------------
  // bus decode
  // ----------------------------------------
  wire                    wr_hit;
  wire                    rd_hit;
  wire [`RSC_FIELD_W-1:0] field_q;
  wire [`RSC_FIELD_W-1:0] field_d;
  wire [`RSC_FIELD_W-1:0] next_field;

  assign wr_hit     = sfr_wr_in & addr_hit(sfr_addr_in);
  assign rd_hit     = sfr_rd_in & addr_hit(sfr_addr_in);
  // upper bits of write data dropped here
  assign field_d    = defined_bits(sfr_wdata_in);
  // outputs take the written value on the same edge as the store
  assign next_field = wr_hit ? field_d : field_q;

  // ----------------------------------------
  // stored field
  // ----------------------------------------
  rsc_field_reg u_field (
    .clk_in     (clk_in),
    .rst_b_in   (rst_b_in),
    .wr_en_in   (wr_hit),
    .wr_data_in (field_d),
    .field_out  (field_q)
  );

  // ----------------------------------------
  // next values of the outputs
  // ----------------------------------------
  wire                   conv0_sel_d;
  wire                   conv1_sel_d;
  wire                   temp_en_d;
  wire                   bias_en_d;
  wire                   buf_en_d;
  reg  [`RSC_DATA_W-1:0] rdata_d;
  reg                    hit_d;

  assign conv0_sel_d = field_bit(next_field, `RSC_BIT_CONV0_SEL);
  assign conv1_sel_d = field_bit(next_field, `RSC_BIT_CONV1_SEL);
  assign temp_en_d   = field_bit(next_field, `RSC_BIT_TEMP_EN);
  assign bias_en_d   = field_bit(next_field, `RSC_BIT_BIAS_EN);
  assign buf_en_d    = field_bit(next_field, `RSC_BIT_BUF_EN);

  // ----------------------------------------
  // read data mux
  // ----------------------------------------
  // a read in the write cycle returns the old value, not the new one
  always @* begin
    rdata_d = {`RSC_DATA_W{1'h0}};
    if (rd_hit) begin
      rdata_d = read_word(field_q);
    end
  end

  // ----------------------------------------
  // acknowledge
  // ----------------------------------------
  // any access to the register, read or write, is acknowledged
  always @* begin
    hit_d = 1'h0;
    if (rd_hit | wr_hit) begin
      hit_d = 1'h1;
    end
  end

  // ----------------------------------------
  // first converter reference select
  // ----------------------------------------
  always @(posedge clk_in) begin
    if (!rst_b_in) begin
      conv0_ref_select_out <= reset_bit(`RSC_BIT_CONV0_SEL);
    end else begin
      conv0_ref_select_out <= conv0_sel_d;
    end
  end

  // ----------------------------------------
  // second converter reference select
  // ----------------------------------------
  always @(posedge clk_in) begin
    if (!rst_b_in) begin
      conv1_ref_select_out <= reset_bit(`RSC_BIT_CONV1_SEL);
    end else begin
      conv1_ref_select_out <= conv1_sel_d;
    end
  end

  // ----------------------------------------
  // temperature sensor enable
  // ----------------------------------------
  always @(posedge clk_in) begin
    if (!rst_b_in) begin
      temp_sensor_enable_out <= reset_bit(`RSC_BIT_TEMP_EN);
    end else begin
      temp_sensor_enable_out <= temp_en_d;
    end
  end

  // ----------------------------------------
  // bias generator enable
  // ----------------------------------------
  // no check against converter use; keeping it set is up to software
  always @(posedge clk_in) begin
    if (!rst_b_in) begin
      bias_generator_enable_out <= reset_bit(`RSC_BIT_BIAS_EN);
    end else begin
      bias_generator_enable_out <= bias_en_d;
    end
  end

  // ----------------------------------------
  // reference buffer enable
  // ----------------------------------------
  always @(posedge clk_in) begin
    if (!rst_b_in) begin
      ref_buffer_enable_out <= reset_bit(`RSC_BIT_BUF_EN);
    end else begin
      ref_buffer_enable_out <= buf_en_d;
    end
  end

  // ----------------------------------------
  // read data register
  // ----------------------------------------
  always @(posedge clk_in) begin
    if (!rst_b_in) begin
      sfr_rdata_out <= {`RSC_DATA_W{1'h0}};
    end else begin
      sfr_rdata_out <= rdata_d;
    end
  end

  // ----------------------------------------
  // acknowledge register
  // ----------------------------------------
  always @(posedge clk_in) begin
    if (!rst_b_in) begin
      sfr_hit_out <= 1'h0;
    end else begin
      sfr_hit_out <= hit_d;
    end
  end

endmodule // rsc_ref_ctrl
`default_nettype wire

// [sim/rsc_ref_ctrl_asserts.sv]
// checker for the reference select control register
`timescale 1ns/1ps
`default_nettype none
module rsc_ref_ctrl_asserts (
  input wire logic       clk_in, rst_b_in, sfr_wr_in, sfr_rd_in, sfr_hit_out,
  input wire logic [7:0] sfr_addr_in, sfr_wdata_in, sfr_rdata_out,
  input wire logic       conv0_ref_select_out, conv1_ref_select_out,
  input wire logic       temp_sensor_enable_out, bias_generator_enable_out,
  input wire logic       ref_buffer_enable_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_b_in);
  // a read that overlaps a write returns the old value, so reads alone are tied to the outputs
  wire w = sfr_wr_in && sfr_addr_in == 8'hd1;
  wire r = sfr_rd_in && sfr_addr_in == 8'hd1 && !sfr_wr_in;
  wire [4:0] o = {conv0_ref_select_out, conv1_ref_select_out, temp_sensor_enable_out,
                  bias_generator_enable_out, ref_buffer_enable_out};
  property p_top; sfr_rdata_out[7:5] == 3'h0; endproperty
  a_top: assert property (p_top) else $error("top bits not zero");
  property p_c0; w |=> conv0_ref_select_out == $past(sfr_wdata_in[4]); endproperty
  a_c0: assert property (p_c0) else $error("conv0 select wrong");
  property p_c1; w |=> conv1_ref_select_out == $past(sfr_wdata_in[3]); endproperty
  a_c1: assert property (p_c1) else $error("conv1 select wrong");
  property p_ts; w |=> temp_sensor_enable_out == $past(sfr_wdata_in[2]); endproperty
  a_ts: assert property (p_ts) else $error("sensor enable wrong");
  property p_bf; w |=> ref_buffer_enable_out == $past(sfr_wdata_in[0]); endproperty
  a_bf: assert property (p_bf) else $error("buffer enable wrong");
  property p_rd; r |=> sfr_hit_out && sfr_rdata_out == {3'h0, o}; endproperty
  a_rd: assert property (p_rd) else $error("read back wrong");
  property p_bs; w |=> bias_generator_enable_out == $past(sfr_wdata_in[1]); endproperty
  a_bs: assert property (p_bs) else $error("bias enable wrong");
  property p_miss;
    (sfr_wr_in || sfr_rd_in) && sfr_addr_in != 8'hd1 |=> !sfr_hit_out && sfr_rdata_out == 8'h00;
  endproperty
  a_miss: assert property (p_miss) else $error("other address answered");
  property p_rst;
    $rose(rst_b_in) |-> o == 5'h00 && sfr_rdata_out == 8'h00 && !sfr_hit_out;
  endproperty
  a_rst: assert property (p_rst) else $error("outputs not cleared by reset");
  c_w: cover property (w);
  c_r: cover property (r);
  c_wr: cover property (w ##1 r);
  c_wrd: cover property (sfr_wr_in && sfr_rd_in && sfr_addr_in == 8'hd1);
  c_rst: cover property ($rose(rst_b_in));
endmodule // rsc_ref_ctrl_asserts
bind rsc_ref_ctrl rsc_ref_ctrl_asserts u_chk (.*);
`default_nettype wire

// [sim/tb_reference_control_register.sv]
// testbench for the reference select control register
`timescale 1ns/1ps
`default_nettype none
module tb_reference_control_register;
  logic clk_in = 0, rst_b_in = 0, sfr_wr_in = 0, sfr_rd_in = 0, hit;
  logic [7:0] sfr_addr_in = 0, sfr_wdata_in = 0, rdata;
  logic [4:0] o;
  int n_errors = 0, tests_run = 0, i;
  always #2.5 clk_in = ~clk_in;
  rsc_ref_ctrl dut (.clk_in(clk_in), .rst_b_in(rst_b_in), .sfr_addr_in(sfr_addr_in),
    .sfr_wr_in(sfr_wr_in), .sfr_rd_in(sfr_rd_in), .sfr_wdata_in(sfr_wdata_in),
    .sfr_rdata_out(rdata), .sfr_hit_out(hit), .conv0_ref_select_out(o[4]),
    .conv1_ref_select_out(o[3]), .temp_sensor_enable_out(o[2]),
    .bias_generator_enable_out(o[1]), .ref_buffer_enable_out(o[0]));
  task chk(input string n, input logic [7:0] s, e);
    tests_run++;
    if (s !== e) begin n_errors++; $display("unexpected %s exp %h got %h", n, e, s); end
  endtask
  task wr(input logic [7:0] a, d);
    @(posedge clk_in); sfr_addr_in <= a; sfr_wdata_in <= d; sfr_wr_in <= 1'b1;
    @(posedge clk_in); sfr_wr_in <= 1'b0;
    #1 chk("whit", {7'h0, hit}, {7'h0, a == 8'hd1});
    if (a == 8'hd1) chk("wctrl", {3'h0, o}, d & 8'h1f);
  endtask
  // write and read in one cycle: old value read back, new value stored
  task wrd(input logic [7:0] d, old);
    @(posedge clk_in); sfr_addr_in <= 8'hd1; sfr_wdata_in <= d;
    sfr_wr_in <= 1'b1; sfr_rd_in <= 1'b1;
    @(posedge clk_in); sfr_wr_in <= 1'b0; sfr_rd_in <= 1'b0;
    #1 chk("wrd rdata", rdata, old);
    chk("wrd ctrl", {3'h0, o}, d & 8'h1f);
  endtask
  task rd(input logic [7:0] a, e);
    @(posedge clk_in); sfr_addr_in <= a; sfr_rd_in <= 1'b1;
    @(posedge clk_in); sfr_rd_in <= 1'b0;
    #1 chk("rdata", rdata, e);
    chk("hit", {7'h0, hit}, {7'h0, a == 8'hd1});
    if (a == 8'hd1) chk("ctrl", {3'h0, o}, e);
  endtask
  task test_done;
    $display("errors %0d checks %0d", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin #5000 n_errors++; test_done; end
  initial begin
    repeat (16) @(posedge clk_in);
    rst_b_in <= 1'b1;
    rd(8'hd1, 8'h00);
    // walking one with the unused top bits set on every write
    for (i = 0; i < 5; i++) begin wr(8'hd1, 8'he0 | (8'h01 << i)); rd(8'hd1, 8'h01 << i); end
    wr(8'hd0, 8'hff); rd(8'hd0, 8'h00); rd(8'hd1, 8'h10);
    wr(8'hd1, 8'hff); rd(8'hd1, 8'h1f);
    wrd(8'h0b, 8'h1f); rd(8'hd1, 8'h0b);
    wr(8'hd1, 8'h03); rd(8'hd1, 8'h03);
    wr(8'hd1, 8'h12); rd(8'hd1, 8'h12);
    wr(8'hd1, 8'h00); rd(8'hd1, 8'h00);
    // reset in mid-run clears the stored bits
    wr(8'hd1, 8'h1f);
    @(posedge clk_in); rst_b_in <= 1'b0;
    repeat (2) @(posedge clk_in);
    rst_b_in <= 1'b1;
    #1 chk("rst ctrl", {3'h0, o}, 8'h00);
    rd(8'hd1, 8'h00);
    test_done;
  end
endmodule // tb_reference_control_register
`default_nettype wire
